// [hdl/smbs_slave.sv]
// two-wire bus slave giving a master access to the monitor registers
// Notes on behaviour
// - address is 01011 plus two strap bits
// - open straps read low, giving 0101100
// - master rewrites only upper five bits
// - slave answers only its current address
// - start is sda falling while scl high
// - eight bits in: address msb first, direction
// - ack matched address by pulling sda low
// - direction zero writes, one reads
// - nine clocks per byte, ack ninth
// - sda rising while scl high is stop
// - direction fixed until next start
// - writes carry one or two bytes; reads one
// - first written byte loads the pointer
// - second written byte goes to pointed register
// - pointer kept between transfers
`timescale 1ns/1ps
module smbs_slave #(
   parameter int FIFO_DEPTH = smbs_pkg::FIFO_DEPTH_DEF
) (
   input logic i_sys_clk,          // system clock, 100 MHz
   input logic i_rst,              // async reset, high
   input logic i_scl,              // bus clock pin
   input logic i_sda_i,            // data pin level
   output logic o_sda_o,           // data pin drive value, always 0
   output logic o_sda_oe_n,        // low pulls data pin low
   input logic i_addr_strap_bit0,  // strap for address bit 0
   input logic i_addr_strap_bit1,  // strap for address bit 1
   output logic o_wr_valid,        // register write ready to hand off
   input logic i_wr_ready,         // core takes the write
   output logic [7:0] o_wr_addr,   // written register index
   output logic [7:0] o_wr_data,   // written register value
   output logic [6:0] o_dev_addr   // address now answered
);
   generate
      if (FIFO_DEPTH < 2) begin : g_bad_fifo
         $error("fifo depth must be at least 2");
      end
   endgenerate

   // pin synchronisers
   logic [1:0] scl_sync_q, sda_sync_q, s0_sync_q, s1_sync_q;
   logic scl_p_q, sda_p_q;
   logic scl, sda;

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         scl_sync_q <= 2'h3;
         sda_sync_q <= 2'h3;
         s0_sync_q <= 2'h0;
         s1_sync_q <= 2'h0;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_sync_q <= {scl_sync_q[0], i_scl};
         sda_sync_q <= {sda_sync_q[0], i_sda_i};
         s0_sync_q <= {s0_sync_q[0], i_addr_strap_bit0};
         s1_sync_q <= {s1_sync_q[0], i_addr_strap_bit1};
         scl_p_q <= scl_sync_q[1];
         sda_p_q <= sda_sync_q[1];
      end
   end

   assign scl = scl_sync_q[1];
   assign sda = sda_sync_q[1];

   logic scl_rise, scl_fall, start_ev, stop_ev;

   assign scl_rise = scl && !scl_p_q;
   assign scl_fall = !scl && scl_p_q;
   assign start_ev = scl && scl_p_q && sda_p_q && !sda;
   assign stop_ev = scl && scl_p_q && !sda_p_q && sda;

   // strap capture after release; the bus is ignored until then
   logic [1:0] strap_cnt_q, strap_q;
   logic strap_ok_q;

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         strap_cnt_q <= 2'h0;
         strap_ok_q <= 1'b0;
         strap_q <= smbs_pkg::STRAP_RST;
      end else if (!strap_ok_q) begin
         if (strap_cnt_q == smbs_pkg::STRAP_SETTLE) begin
            strap_q <= {s1_sync_q[1], s0_sync_q[1]};
            strap_ok_q <= 1'b1;
         end else begin
            strap_cnt_q <= strap_cnt_q + 2'h1;
         end
      end
   end

   smbs_pkg::smbs_state_t state_q;
   logic [3:0] cnt_q;
   logic [7:0] shift_q;
   logic [7:0] tx_q;
   logic [1:0] nbyte_q;
   logic rw_q;
   logic [7:0] ptr_q;
   logic [4:0] addr_hi_q;
   logic sda_oe_n_q;
   logic [6:0] own_addr;
   logic byte_end;
   logic addr_match;
   logic data_take;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [15:0] fifo_out_data;
   logic [7:0] mem_rdata;
   logic wr_valid_q;
   logic [7:0] wr_addr_q;
   logic [7:0] wr_data_q;
   logic mem_we;

   assign own_addr = {addr_hi_q, strap_q};
   assign byte_end = (state_q == smbs_pkg::ST_RX) && scl_fall
                     && (cnt_q == smbs_pkg::BITS_PER_BYTE);
   assign addr_match = (shift_q[7:1] == own_addr);
   // a full fifo refuses the data byte, which shows as a nack
   assign data_take = byte_end && (nbyte_q == smbs_pkg::NB_DATA) && fifo_in_ready;

   // bus sequencer
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         state_q <= smbs_pkg::ST_IDLE;
         cnt_q <= 4'h0;
         shift_q <= 8'h00;
         tx_q <= 8'h00;
         nbyte_q <= smbs_pkg::NB_ADDR;
         rw_q <= 1'b0;
         sda_oe_n_q <= 1'b1;
      end else if (stop_ev) begin
         state_q <= smbs_pkg::ST_IDLE;
         sda_oe_n_q <= 1'b1;
      end else if (start_ev && strap_ok_q) begin
         state_q <= smbs_pkg::ST_RX;
         cnt_q <= 4'h0;
         nbyte_q <= smbs_pkg::NB_ADDR;
         sda_oe_n_q <= 1'b1;
      end else begin
         unique case (state_q)
            smbs_pkg::ST_IDLE, smbs_pkg::ST_IGNORE: begin
               sda_oe_n_q <= 1'b1;
            end
            smbs_pkg::ST_RX: begin
               if (scl_rise && cnt_q != smbs_pkg::BITS_PER_BYTE) begin
                  shift_q <= {shift_q[6:0], sda};
                  cnt_q <= cnt_q + 4'h1;
               end else if (byte_end) begin
                  unique case (nbyte_q)
                     smbs_pkg::NB_ADDR: begin
                        if (addr_match) begin
                           rw_q <= shift_q[0];
                           sda_oe_n_q <= 1'b0;
                           state_q <= smbs_pkg::ST_ACK;
                        end else begin
                           state_q <= smbs_pkg::ST_IGNORE;
                        end
                     end
                     smbs_pkg::NB_PTR: begin
                        sda_oe_n_q <= 1'b0;
                        state_q <= smbs_pkg::ST_ACK;
                     end
                     smbs_pkg::NB_DATA: begin
                        if (fifo_in_ready) begin
                           sda_oe_n_q <= 1'b0;
                           state_q <= smbs_pkg::ST_ACK;
                        end else begin
                           state_q <= smbs_pkg::ST_IGNORE;
                        end
                     end
                     smbs_pkg::NB_EXTRA: begin
                        state_q <= smbs_pkg::ST_IGNORE;
                     end
                  endcase
               end
            end
            smbs_pkg::ST_ACK: begin
               if (scl_fall) begin
                  nbyte_q <= nbyte_q + 2'h1;
                  cnt_q <= 4'h0;
                  if (rw_q && nbyte_q == smbs_pkg::NB_ADDR) begin
                     tx_q <= mem_rdata;
                     sda_oe_n_q <= mem_rdata[7];
                     state_q <= smbs_pkg::ST_TX;
                  end else begin
                     sda_oe_n_q <= 1'b1;
                     state_q <= smbs_pkg::ST_RX;
                  end
               end
            end
            smbs_pkg::ST_TX: begin
               if (scl_fall) begin
                  if (cnt_q == smbs_pkg::TX_LAST_BIT) begin
                     sda_oe_n_q <= 1'b1;
                     state_q <= smbs_pkg::ST_TXACK;
                  end else begin
                     tx_q <= {tx_q[6:0], 1'b0};
                     sda_oe_n_q <= tx_q[6];
                     cnt_q <= cnt_q + 4'h1;
                  end
               end
            end
            smbs_pkg::ST_TXACK: begin
               // one read byte, whatever the master answers
               if (scl_rise) begin
                  state_q <= smbs_pkg::ST_IGNORE;
               end
            end
            default: begin
               state_q <= smbs_pkg::ST_IDLE;
               sda_oe_n_q <= 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         ptr_q <= smbs_pkg::PTR_RST;
      end else if (byte_end && nbyte_q == smbs_pkg::NB_PTR) begin
         ptr_q <= shift_q;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         addr_hi_q <= smbs_pkg::ADDR_HI_RST;
      end else if (data_take && ptr_q == smbs_pkg::SADDR_REG_OFS) begin
         addr_hi_q <= shift_q[6:2];
      end
   end

   // data byte queued for pointed register
   smbs_fifo #(
      .WIDTH(16),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_in_valid(data_take),
      .o_in_ready(fifo_in_ready),
      .i_in_data({ptr_q, shift_q}),
      .o_out_valid(fifo_out_valid),
      .i_out_ready(fifo_out_ready),
      .o_out_data(fifo_out_data)
   );

   // output stage; a stalled core backs up the fifo
   assign fifo_out_ready = !wr_valid_q || i_wr_ready;
   assign mem_we = fifo_out_valid && fifo_out_ready;

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         wr_valid_q <= 1'b0;
         wr_addr_q <= 8'h00;
         wr_data_q <= 8'h00;
      end else if (fifo_out_ready) begin
         wr_valid_q <= fifo_out_valid;
         if (fifo_out_valid) begin
            wr_addr_q <= fifo_out_data[15:8];
            wr_data_q <= fifo_out_data[7:0];
         end
      end
   end

   // reads see a write only once it has left the fifo
   smbs_regmem #(
      .AW(8),
      .DW(8)
   ) u_regs (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_we(mem_we),
      .i_waddr(fifo_out_data[15:8]),
      .i_wdata(fifo_out_data[7:0]),
      .i_raddr(ptr_q),
      .o_rdata(mem_rdata)
   );

   assign o_sda_o = 1'b0;
   assign o_sda_oe_n = sda_oe_n_q;
   assign o_wr_valid = wr_valid_q;
   assign o_wr_addr = wr_addr_q;
   assign o_wr_data = wr_data_q;
   assign o_dev_addr = own_addr;

   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_rst);
   sequence s_addr_done;
      byte_end && nbyte_q == smbs_pkg::NB_ADDR;
   endsequence
   sequence s_ack_end;
      state_q == smbs_pkg::ST_ACK && scl_fall;
   endsequence
   property p_start_rx;
      start_ev && strap_ok_q && !stop_ev |=> state_q == smbs_pkg::ST_RX && cnt_q == 4'h0;
   endproperty
   a_start_rx: assert property (p_start_rx) else $error("start not taken");
   property p_stop_idle;
      stop_ev |=> state_q == smbs_pkg::ST_IDLE && o_sda_oe_n;
   endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("stop not taken");
   property p_ack_match;
      s_addr_done ##0 addr_match |=> !o_sda_oe_n [*2];
   endproperty
   a_ack_match: assert property (p_ack_match) else $error("no ack on match");
   property p_no_match;
      s_addr_done ##0 !addr_match |=> o_sda_oe_n && state_q == smbs_pkg::ST_IGNORE;
   endproperty
   a_no_match: assert property (p_no_match) else $error("ack on foreign addr");
   property p_ptr_load;
      byte_end && nbyte_q == smbs_pkg::NB_PTR |=> ptr_q == $past(shift_q);
   endproperty
   a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded");
   property p_addr_hi;
      data_take && ptr_q == smbs_pkg::SADDR_REG_OFS
         |=> o_dev_addr[6:2] == 5'($past(shift_q) >> 2) && o_dev_addr[1:0] == strap_q;
   endproperty
   a_addr_hi: assert property (p_addr_hi) else $error("address not updated");
   property p_addr_rst;
      !strap_ok_q |-> addr_hi_q == smbs_pkg::ADDR_HI_RST;
   endproperty
   a_addr_rst: assert property (p_addr_rst) else $error("bad default address");
   property p_extra_nack;
      byte_end && nbyte_q == smbs_pkg::NB_EXTRA
         |=> o_sda_oe_n && state_q == smbs_pkg::ST_IGNORE;
   endproperty
   a_extra_nack: assert property (p_extra_nack) else $error("third byte acked");
   property p_tx_first;
      s_ack_end ##0 rw_q && nbyte_q == smbs_pkg::NB_ADDR
         |=> o_sda_oe_n == 1'($past(mem_rdata) >> 7) && state_q == smbs_pkg::ST_TX;
   endproperty
   a_tx_first: assert property (p_tx_first) else $error("read msb wrong");
   property p_tx_release;
      state_q == smbs_pkg::ST_TX && scl_fall && cnt_q == smbs_pkg::TX_LAST_BIT
         |=> o_sda_oe_n && state_q == smbs_pkg::ST_TXACK;
   endproperty
   a_tx_release: assert property (p_tx_release) else $error("no release");
   property p_write_dir;
      s_ack_end ##0 !rw_q |=> state_q == smbs_pkg::ST_RX && o_sda_oe_n;
   endproperty
   a_write_dir: assert property (p_write_dir) else $error("write dir lost");
endmodule // smbs_slave

// [hdl/smbs_pkg.sv]
// shared constants and state encoding for the serial-bus slave
package smbs_pkg;
   // upper five address bits after power-up (01011)
   localparam logic [4:0] ADDR_HI_RST = 5'h0b;
   // register offset whose write reloads the upper address bits
   localparam logic [7:0] SADDR_REG_OFS = 8'h48;
   localparam logic [7:0] PTR_RST = 8'h00;
   localparam logic [1:0] STRAP_RST = 2'h0;
   // sys clocks between reset release and strap capture
   localparam logic [1:0] STRAP_SETTLE = 2'h2;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] TX_LAST_BIT = 4'h7;
   // byte index within one transfer
   localparam logic [1:0] NB_ADDR = 2'h0;
   localparam logic [1:0] NB_PTR = 2'h1;
   localparam logic [1:0] NB_DATA = 2'h2;
   localparam logic [1:0] NB_EXTRA = 2'h3;
   localparam int FIFO_DEPTH_DEF = 4;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RX = 3'b001,
      ST_ACK = 3'b010,
      ST_TX = 3'b011,
      ST_TXACK = 3'b100,
      ST_IGNORE = 3'b101
   } smbs_state_t;
endpackage

// [hdl/smbs_fifo.sv]
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module smbs_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   input logic i_sys_clk,              // system clock
   input logic i_rst,                  // async reset, high
   input logic i_in_valid,             // write request
   output logic o_in_ready,            // space available
   input logic [WIDTH-1:0] i_in_data,  // write word
   output logic o_out_valid,           // word available
   input logic i_out_ready,            // reader takes word
   output logic [WIDTH-1:0] o_out_data // head word
);
   localparam int AW = $clog2(DEPTH);

   generate
      if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
         $error("fifo depth must be a power of two, at least 2");
      end
   endgenerate

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0] wr_q;
   logic [AW:0] rd_q;
   logic full;
   logic empty;

   assign empty = (wr_q == rd_q);
   assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
   assign o_in_ready = !full;
   assign o_out_valid = !empty;
   assign o_out_data = mem_q[rd_q[AW-1:0]];

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (i_in_valid && !full) begin
            wr_q <= wr_q + 1'b1;
         end
         if (i_out_ready && !empty) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end

   // storage needs no reset; only written words are ever read
   always_ff @(posedge i_sys_clk) begin
      if (i_in_valid && !full) begin
         mem_q[wr_q[AW-1:0]] <= i_in_data;
      end
   end
endmodule // smbs_fifo

// [hdl/smbs_regmem.sv]
// register image with one write port and a registered read port
`timescale 1ns/1ps
module smbs_regmem #(
   parameter int AW = 8,
   parameter int DW = 8
) (
   input logic i_sys_clk,          // system clock
   input logic i_rst,              // async reset, high
   input logic i_we,               // write strobe
   input logic [AW-1:0] i_waddr,   // write index
   input logic [DW-1:0] i_wdata,   // write data
   input logic [AW-1:0] i_raddr,   // read index
   output logic [DW-1:0] o_rdata   // read data, one cycle late
);
   generate
      if (AW < 1 || AW > 8 || DW < 1) begin : g_bad_size
         $error("regmem size out of range");
      end
   endgenerate

   logic [DW-1:0] mem_q [1 << AW];

   // cleared so a read before any write returns zeros, not unknowns
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         for (int i = 0; i < (1 << AW); i++) begin
            mem_q[i] <= '0;
         end
      end else if (i_we) begin
         mem_q[i_waddr] <= i_wdata;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rdata <= '0;
      end else begin
         o_rdata <= mem_q[i_raddr];
      end
   end
endmodule // smbs_regmem

// [verif/smbs_master_model.sv]
// bus master model pacing clock and data from the system clock
`timescale 1ns/1ps
module smbs_master_model (
   input wire logic i_clk,  // system clock used for pacing
   input wire logic i_sda,  // resolved data wire
   output logic o_scl,      // bus clock, idles high
   output logic o_sda_oe_n  // low pulls the data wire low
);
   initial begin
      o_scl = 1'b1;
      o_sda_oe_n = 1'b1;
   end
   // a quarter of the 160 ns bus period
   task automatic qtr();
      repeat (4) @(negedge i_clk);
   endtask
   task automatic put_bit(input logic b, output logic r);
      qtr();
      o_sda_oe_n = b;
      qtr();
      o_scl = 1'b1;
      qtr();
      r = i_sda;
      qtr();
      o_scl = 1'b0;
   endtask
   // eight bits then the slave ack
   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) put_bit(d[i], r);
      put_bit(1'b1, r);
      ack = ~r;
   endtask
   task automatic xfer(input logic [6:0] a, input logic rd, input logic [23:0] bytes,
      input int n, output logic [3:0] acks, output logic [7:0] rdat);
      logic r;
      acks = '0;
      rdat = '0;
      qtr();
      o_sda_oe_n = 1'b0;
      qtr();
      o_scl = 1'b0;
      send_byte({a, rd}, acks[0]);
      if (acks[0] && rd) begin
         for (int i = 7; i >= 0; i--) put_bit(1'b1, rdat[i]);
         put_bit(1'b1, r);
      end else if (acks[0]) begin
         for (int k = 0; k < n; k++) begin
            send_byte(bytes[23-8*k -: 8], acks[k+1]);
            if (!acks[k+1]) break;
         end
      end
      // low, clock up, then data rises
      qtr();
      o_sda_oe_n = 1'b0;
      qtr();
      o_scl = 1'b1;
      qtr();
      o_sda_oe_n = 1'b1;
      qtr();
   endtask
endmodule // smbs_master_model

// [verif/test_smbus_slave_register_access.sv]
// self-checking bench for the serial-bus slave
`timescale 1ns/1ps
module test_smbus_slave_register_access;
   localparam int FD = smbs_pkg::FIFO_DEPTH_DEF;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic scl, m_oe_n, sda, sda_o, s_oe_n, wr_valid;
   logic strap0 = 1'b0;
   logic strap1 = 1'b0;
   logic wr_ready = 1'b0;
   logic rdy_en = 1'b0;
   logic [7:0] wr_addr, wr_data;
   logic [6:0] dev_addr, cur;
   logic [15:0] exp_q[$];
   logic [7:0] mem[256];
   int failures = 0;
   int num_checks = 0;

   always #5 sys_clk = ~sys_clk;
   // open-drain data wire with pull-up
   assign sda = m_oe_n & s_oe_n;

   smbs_slave #(.FIFO_DEPTH(FD)) u_smbs_slave (
      .i_sys_clk(sys_clk), .i_rst(rst), .i_scl(scl), .i_sda_i(sda), .o_sda_o(sda_o),
      .o_sda_oe_n(s_oe_n), .i_addr_strap_bit0(strap0), .i_addr_strap_bit1(strap1),
      .o_wr_valid(wr_valid), .i_wr_ready(wr_ready), .o_wr_addr(wr_addr),
      .o_wr_data(wr_data), .o_dev_addr(dev_addr));
   smbs_master_model u_smbs_master_model (
      .i_clk(sys_clk), .i_sda(sda), .o_scl(scl), .o_sda_oe_n(m_oe_n));

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic tdone(input string n);
      $display("test %s finished", n);
   endtask

   // the core side stalls at random while the stream is enabled
   always @(negedge sys_clk) wr_ready <= rdy_en & 1'($urandom % 2);
   always @(posedge sys_clk) begin
      if (!rst && wr_valid && wr_ready) begin
         if (exp_q.size() == 0) check("stream_extra", 16'h0, 16'h1);
         else check("stream_word", {wr_addr, wr_data}, exp_q.pop_front());
      end
   end

   task automatic do_reset(input logic [1:0] s);
      rst = 1'b1;
      {strap1, strap0} = s;
      repeat (20) @(negedge sys_clk);
      rst = 1'b0;
      repeat (10) @(negedge sys_clk);
      foreach (mem[i]) mem[i] = 8'h00;
      exp_q.delete();
   endtask
   task automatic wr_reg(input logic [7:0] p, input logic [7:0] d, output logic ok);
      logic [3:0] acks;
      logic [7:0] rd;
      // noted before the transfer: the word can leave the slave before the stop
      exp_q.push_back({p, d});
      u_smbs_master_model.xfer(cur, 1'b0, {p, d, 8'h00}, 2, acks, rd);
      ok = acks[2];
      if (ok) mem[p] = d;
      else void'(exp_q.pop_back());
   endtask
   // pointer-only write, then a separate read
   task automatic rd_reg(input logic set_ptr, input logic [7:0] p, output logic [7:0] v);
      logic [3:0] acks;
      if (set_ptr) u_smbs_master_model.xfer(cur, 1'b0, {p, 16'h0}, 1, acks, v);
      u_smbs_master_model.xfer(cur, 1'b1, 24'h0, 0, acks, v);
   endtask
   task automatic drain();
      for (int i = 0; i < 3000 && exp_q.size() != 0; i++) @(negedge sys_clk);
      repeat (20) @(negedge sys_clk);
      check("drained", 16'(exp_q.size()), 16'h0);
   endtask

   initial begin
      repeat (40000) @(posedge sys_clk);
      failures++;
      give_verdict();
   end

   initial begin
      logic [3:0] acks;
      logic [7:0] v, d, rd;
      logic [1:0] strap;
      logic [4:0] hi;
      logic ok, got_nack;
      int acc;
      void'($urandom(16));
      strap = 2'($urandom % 4);
      do_reset(strap);
      rdy_en = 1'b1;
      cur = {smbs_pkg::ADDR_HI_RST, strap};
      check("dev_addr", 16'(dev_addr), 16'(cur));
      check("sda_drive", 16'(sda_o), 16'h0);
      tdone("reset_address");
      u_smbs_master_model.xfer({smbs_pkg::ADDR_HI_RST, ~strap}, 1'b0, 24'h010000, 1, acks, rd);
      check("foreign_acks", 16'(acks), 16'h0);
      tdone("foreign_address");
      d = 8'($urandom);
      wr_reg(8'h21, d, ok);
      check("write_ack", 16'(ok), 16'h1);
      drain();
      rd_reg(1'b1, 8'h21, v);
      check("read_set_ptr", 16'(v), 16'(mem[8'h21]));
      rd_reg(1'b0, 8'h00, v);
      check("read_kept_ptr", 16'(v), 16'(mem[8'h21]));
      tdone("write_then_read");
      d = 8'($urandom);
      exp_q.push_back({8'h30, d});
      u_smbs_master_model.xfer(cur, 1'b0, {8'h30, d, 8'h5a}, 3, acks, rd);
      check("three_byte_acks", 16'(acks), 16'h7);
      mem[8'h30] = d;
      drain();
      tdone("extra_byte");
      hi = 5'($urandom);
      if (hi == smbs_pkg::ADDR_HI_RST) hi = ~hi;
      d = {1'($urandom), hi, 2'($urandom)};
      wr_reg(smbs_pkg::SADDR_REG_OFS, d, ok);
      drain();
      check("new_dev_addr", 16'(dev_addr), 16'({hi, strap}));
      u_smbs_master_model.xfer(cur, 1'b1, 24'h0, 0, acks, rd);
      check("old_addr_ack", 16'(acks), 16'h0);
      cur = {hi, strap};
      rd_reg(1'b0, 8'h00, v);
      check("new_addr_read", 16'(v), 16'(mem[smbs_pkg::SADDR_REG_OFS]));
      tdone("address_change");
      rdy_en = 1'b0;
      acc = 0;
      got_nack = 1'b0;
      repeat (2) @(negedge sys_clk);
      for (int k = 0; k < 8 && !got_nack; k++) begin
         wr_reg(8'(8'h40 + k), 8'($urandom), ok);
         if (ok) acc++;
         else got_nack = 1'b1;
      end
      check("full_refused", 16'(got_nack), 16'h1);
      check("full_depth", 16'(acc >= FD), 16'h1);
      rdy_en = 1'b1;
      drain();
      rd_reg(1'b1, 8'h40, v);
      check("after_full_read", 16'(v), 16'(mem[8'h40]));
      tdone("fifo_full");
      do_reset(2'h0);
      cur = 7'h2c;
      check("open_strap_addr", 16'(dev_addr), 16'h002c);
      rd_reg(1'b0, 8'h00, v);
      check("reset_read", 16'(v), 16'h0000);
      tdone("open_straps");
      give_verdict();
   end
endmodule // test_smbus_slave_register_access
